// ---- common/bst_pkg.sv ----
`default_nettype none
package bst_pkg;

  localparam int IR_W = 8;
  localparam int BSR_W = 18;
  localparam int BCR_W = 2;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_RESET = 8'h7F;
  localparam logic [1:0] BCR_RESET = 2'h2;
  localparam int CELL_OE_LO = 16;
  localparam int CELL_A_LO = 8;
  localparam int CELL_Y_LO = 0;
  localparam logic [2:0] TMS_RESET_CYCLES = 3'h5;

  ////////////////////////////////////////////////////////////////
  // Gray codes along the usual path
  typedef enum logic [3:0] {
    BST_RESET = 4'h0,
    BST_IDLE = 4'h1,
    BST_SEL_DR = 4'h3,
    BST_CAP_DR = 4'h2,
    BST_SH_DR = 4'h6,
    BST_EX1_DR = 4'h7,
    BST_PAU_DR = 4'h5,
    BST_EX2_DR = 4'h4,
    BST_UPD_DR = 4'hC,
    BST_SEL_IR = 4'hD,
    BST_CAP_IR = 4'hF,
    BST_SH_IR = 4'hE,
    BST_EX1_IR = 4'hA,
    BST_PAU_IR = 4'hB,
    BST_EX2_IR = 4'h9,
    BST_UPD_IR = 4'h8
  } bst_state_type;

  typedef enum logic [1:0] {
    BST_PATH_BYP = 2'h0,
    BST_PATH_BSR = 2'h1,
    BST_PATH_BCR = 2'h2
  } bst_path_type;

  // a[7] is group1_data_in_1, a[0] group2 input 4; y likewise
  typedef struct packed {
    logic [1:0] oe_n;
    logic [7:0] a;
    logic [7:0] y;
  } bst_pin_type;

  typedef struct packed {
    logic test_mode;
    bst_path_type path;
    logic [BSR_W-1:0] cells;
    logic [BCR_W-1:0] op;
  } bst_ctl_type;

  ////////////////////////////////////////////////////////////////
  // Bit 7 is a don't-care, no parity check
  function automatic bst_path_type bst_dec_path(input logic [IR_W-1:0] code);
    case (code[6:0])
      7'h00, 7'h02, 7'h03, 7'h0A, 7'h0B, 7'h0C: bst_dec_path = BST_PATH_BSR;
      7'h0E, 7'h0F: bst_dec_path = BST_PATH_BCR;
      default: bst_dec_path = BST_PATH_BYP;
    endcase
  endfunction

  function automatic logic bst_dec_test(input logic [IR_W-1:0] code);
    case (code[6:0])
      7'h00, 7'h03, 7'h06, 7'h07, 7'h09, 7'h0B, 7'h0D, 7'h0F: bst_dec_test = 1'b1;
      default: bst_dec_test = 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- design/bst_tap.sv ----
`timescale 1ns/1ps
`default_nettype none
module bst_tap (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire bst_pkg::bst_pin_type pins,
  output logic tdo,
  output logic tdo_oe_n,
  output bst_pkg::bst_ctl_type ctl
);
  import bst_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Rising-edge TCK state
  typedef struct packed {
    logic rs1;
    logic rs2;
    bst_pin_type p1;
    bst_pin_type p2;
    bst_state_type st;
    logic [2:0] tms_cnt;
    logic [IR_W-1:0] ir_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BCR_W-1:0] bcr_sh;
    logic byp;
  } bst_rise_type;

  // Falling-edge TCK state
  typedef struct packed {
    logic [IR_W-1:0] ir_upd;
    logic [BSR_W-1:0] bsr_upd;
    logic [BCR_W-1:0] bcr_upd;
    logic tdo;
    logic oe_n;
    logic tog;
  } bst_fall_type;

  // System clock state
  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    bst_ctl_type ctl;
  } bst_sys_type;

  bst_rise_type r_ff;
  bst_rise_type nxt_r;
  bst_fall_type f_ff;
  bst_fall_type nxt_f;
  bst_sys_type s_ff;
  bst_sys_type nxt_s;
  bst_path_type path;

  assign path = bst_dec_path(f_ff.ir_upd);

  ////////////////////////////////////////////////////////////////
  function automatic bst_state_type next_state(
    input bst_state_type cur,
    input logic m
  );
    case (cur)
      BST_RESET: next_state = m ? BST_RESET : BST_IDLE;
      BST_IDLE: next_state = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: next_state = m ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: next_state = m ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: next_state = m ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: next_state = m ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: next_state = m ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: next_state = m ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: next_state = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: next_state = m ? BST_RESET : BST_CAP_IR;
      BST_CAP_IR: next_state = m ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: next_state = m ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: next_state = m ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: next_state = m ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: next_state = m ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: next_state = m ? BST_SEL_DR : BST_IDLE;
      default: next_state = BST_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // TMS and TDI belong to this domain; pins and rst do not
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rs1 = rst;
    nxt_r.rs2 = r_ff.rs1;
    nxt_r.p1 = pins;
    nxt_r.p2 = r_ff.p1;
    nxt_r.st = next_state(r_ff.st, tms);
    if (!tms) begin
      nxt_r.tms_cnt = 3'h0;
    end else if (r_ff.tms_cnt != TMS_RESET_CYCLES) begin
      nxt_r.tms_cnt = r_ff.tms_cnt + 3'h1;
    end
    case (r_ff.st)
      BST_CAP_DR: begin
        case (path)
          BST_PATH_BSR: nxt_r.bsr_sh = {r_ff.p2.oe_n, r_ff.p2.a, r_ff.p2.y};
          BST_PATH_BYP: nxt_r.byp = 1'b0;
          default: nxt_r.bcr_sh = r_ff.bcr_sh;
        endcase
      end
      BST_SH_DR: begin
        // Entry cycle is Capture or Exit2, so no shift happens there
        case (path)
          BST_PATH_BSR: nxt_r.bsr_sh = {tdi, r_ff.bsr_sh[BSR_W-1:1]};
          BST_PATH_BCR: nxt_r.bcr_sh = {tdi, r_ff.bcr_sh[BCR_W-1]};
          default: nxt_r.byp = tdi;
        endcase
      end
      BST_CAP_IR: nxt_r.ir_sh = IR_CAPTURE;
      BST_SH_IR: nxt_r.ir_sh = {tdi, r_ff.ir_sh[IR_W-1:1]};
      default: nxt_r.ir_sh = r_ff.ir_sh;
    endcase
    if (r_ff.rs2) begin
      nxt_r.st = BST_RESET;
      nxt_r.tms_cnt = 3'h0;
      nxt_r.ir_sh = IR_RESET;
      nxt_r.bsr_sh = '0;
      nxt_r.bcr_sh = BCR_RESET;
      nxt_r.byp = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    r_ff <= nxt_r;
  end

  ////////////////////////////////////////////////////////////////
  // Shadows and TDO move on the falling edge only
  always_comb begin
    nxt_f = f_ff;
    case (r_ff.st)
      BST_RESET: begin
        // Chain shadow is deliberately left alone here
        nxt_f.ir_upd = IR_RESET;
        nxt_f.bcr_upd = BCR_RESET;
        if (f_ff.ir_upd != IR_RESET || f_ff.bcr_upd != BCR_RESET) begin
          nxt_f.tog = ~f_ff.tog;
        end
      end
      BST_UPD_IR: begin
        nxt_f.ir_upd = r_ff.ir_sh;
        nxt_f.tog = ~f_ff.tog;
      end
      BST_UPD_DR: begin
        case (path)
          BST_PATH_BSR: begin
            nxt_f.bsr_upd = r_ff.bsr_sh;
            nxt_f.tog = ~f_ff.tog;
          end
          BST_PATH_BCR: begin
            nxt_f.bcr_upd = r_ff.bcr_sh;
            nxt_f.tog = ~f_ff.tog;
          end
          default: nxt_f.tog = f_ff.tog;
        endcase
      end
      default: nxt_f.tog = f_ff.tog;
    endcase
    if (r_ff.st == BST_SH_IR) begin
      nxt_f.oe_n = 1'b0;
      nxt_f.tdo = r_ff.ir_sh[0];
    end else if (r_ff.st == BST_SH_DR) begin
      nxt_f.oe_n = 1'b0;
      case (path)
        BST_PATH_BSR: nxt_f.tdo = r_ff.bsr_sh[0];
        BST_PATH_BCR: nxt_f.tdo = r_ff.bcr_sh[0];
        default: nxt_f.tdo = r_ff.byp;
      endcase
    end else begin
      nxt_f.oe_n = 1'b1;
    end
    if (r_ff.rs2) begin
      nxt_f = '0;
      nxt_f.ir_upd = IR_RESET;
      nxt_f.bcr_upd = BCR_RESET;
      nxt_f.oe_n = 1'b1;
    end
  end

  always_ff @(negedge tck) begin
    f_ff <= nxt_f;
  end

  ////////////////////////////////////////////////////////////////
  // Toggle crossing: shadows stay put for many TCK periods after
  // a toggle, far longer than the three clk edges needed here.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.t1 = f_ff.tog;
    nxt_s.t2 = s_ff.t1;
    nxt_s.t3 = s_ff.t2;
    if (s_ff.t2 != s_ff.t3) begin
      nxt_s.ctl.test_mode = bst_dec_test(f_ff.ir_upd);
      nxt_s.ctl.path = bst_dec_path(f_ff.ir_upd);
      nxt_s.ctl.cells = f_ff.bsr_upd;
      nxt_s.ctl.op = f_ff.bcr_upd;
    end
    if (rst) begin
      nxt_s.ctl.test_mode = 1'b0;
      nxt_s.ctl.path = BST_PATH_BYP;
      nxt_s.ctl.cells = '0;
      nxt_s.ctl.op = BCR_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s_ff <= nxt_s;
  end

  assign tdo = f_ff.tdo;
  assign tdo_oe_n = f_ff.oe_n;
  assign ctl = s_ff.ctl;

  ////////////////////////////////////////////////////////////////
  AST_CAP_IR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_CAP_IR |=> r_ff.ir_sh == IR_CAPTURE)
    else $error("capture-IR value wrong");

  AST_SHIFT_IR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_SH_IR |=> r_ff.ir_sh == {$past(tdi), $past(r_ff.ir_sh[IR_W-1:1])})
    else $error("IR did not shift one bit");

  AST_BYP_ZERO: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_CAP_DR && path == BST_PATH_BYP) |=> !r_ff.byp)
    else $error("bypass did not capture zero");

  AST_PAUSE_DR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_PAU_DR |=> $stable(r_ff.bsr_sh) && $stable(r_ff.bcr_sh) && $stable(r_ff.byp))
    else $error("pause-DR lost data");

  AST_PAUSE_IR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_PAU_IR [*2] |-> $stable(r_ff.ir_sh))
    else $error("pause-IR lost data");

  AST_RESUME_DR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_EX2_DR && !tms) |=> r_ff.st == BST_SH_DR && $stable(r_ff.bsr_sh))
    else $error("exit2-DR did not resume shift");

  AST_TMS_RESET: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.tms_cnt == TMS_RESET_CYCLES |-> r_ff.st == BST_RESET)
    else $error("five TMS highs did not reset");

  AST_TDO_OFF: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_EX1_DR || r_ff.st == BST_EX1_IR) |=> f_ff.oe_n)
    else $error("TDO not released in exit1");

  AST_TDO_IR: assert property (@(negedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_SH_IR |=> !f_ff.oe_n && f_ff.tdo == $past(r_ff.ir_sh[0]))
    else $error("TDO not driving IR lsb");

  AST_UPD_IR: assert property (@(negedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_UPD_IR |=> f_ff.ir_upd == $past(r_ff.ir_sh))
    else $error("instruction not latched");

  AST_TLR_IR: assert property (@(negedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_RESET |=> f_ff.ir_upd == IR_RESET && $stable(f_ff.bsr_upd))
    else $error("reset state mishandled IR or chain");

  ////////////////////////////////////////////////////////////////
  // Data-register paths, rising edge
  AST_CAP_BSR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_CAP_DR && path == BST_PATH_BSR) |=> r_ff.bsr_sh == $past(r_ff.p2))
    else $error("chain capture did not load pins");

  AST_CAP_BCR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_CAP_DR && path == BST_PATH_BCR) |=> $stable(r_ff.bcr_sh))
    else $error("control register changed in capture");

  AST_CAP_KEEP_IR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_CAP_DR |=> $stable(r_ff.ir_sh))
    else $error("instruction stage changed in data capture");

  AST_SHIFT_BSR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_SH_DR && path == BST_PATH_BSR) |=>
      r_ff.bsr_sh == {$past(tdi), $past(r_ff.bsr_sh[BSR_W-1:1])})
    else $error("chain did not shift one cell");

  AST_SHIFT_BYP: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_SH_DR && path == BST_PATH_BYP) |=> r_ff.byp == $past(tdi))
    else $error("bypass did not take TDI");

  AST_EX1_DR_HOLD: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_EX1_DR |=> $stable(r_ff.bsr_sh) && $stable(r_ff.bcr_sh) && $stable(r_ff.byp))
    else $error("exit1-DR altered data");

  AST_TLR_CHAIN: assert property (@(posedge tck) disable iff (r_ff.rs2)
    r_ff.st == BST_RESET |=> $stable(r_ff.bsr_sh))
    else $error("reset state altered chain stage");

  // Instruction path, rising edge
  AST_EX_IR_HOLD: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_EX1_IR || r_ff.st == BST_EX2_IR) |=> $stable(r_ff.ir_sh))
    else $error("exit-IR altered instruction stage");

  AST_RESUME_IR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_EX2_IR && !tms) |=> r_ff.st == BST_SH_IR)
    else $error("exit2-IR did not resume shift");

  // Controller graph spot checks
  AST_SEL_IR_TLR: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_SEL_IR && tms) |=> r_ff.st == BST_RESET)
    else $error("select-IR did not fall back to reset");

  AST_IDLE_HOLD: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_IDLE && !tms) |=> r_ff.st == BST_IDLE)
    else $error("idle not held");

  AST_SEL_DR_CAP: assert property (@(posedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_SEL_DR && !tms) |=> r_ff.st == BST_CAP_DR)
    else $error("select-DR did not enter capture");

  ////////////////////////////////////////////////////////////////
  // Falling-edge shadows and TDO
  AST_UPD_DR: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_UPD_DR && path == BST_PATH_BSR) |=> f_ff.bsr_upd == $past(r_ff.bsr_sh))
    else $error("chain shadow not updated");

  AST_UPD_BCR: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_UPD_DR && path == BST_PATH_BCR) |=> f_ff.bcr_upd == $past(r_ff.bcr_sh))
    else $error("control shadow not updated");

  AST_UPD_BYP: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_UPD_DR && path == BST_PATH_BYP) |=> $stable(f_ff.bsr_upd) && $stable(f_ff.bcr_upd))
    else $error("bypass update touched a shadow");

  AST_TDO_DR: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_SH_DR && path == BST_PATH_BSR) |=> !f_ff.oe_n && f_ff.tdo == $past(r_ff.bsr_sh[0]))
    else $error("TDO not driving chain cell 0");

  AST_TDO_BYP: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st == BST_SH_DR && path == BST_PATH_BYP) |=> f_ff.tdo == $past(r_ff.byp))
    else $error("TDO not driving bypass bit");

  AST_TDO_HIZ: assert property (@(negedge tck) disable iff (r_ff.rs2)
    (r_ff.st != BST_SH_DR && r_ff.st != BST_SH_IR) |=> f_ff.oe_n)
    else $error("TDO driven outside shift");

  ////////////////////////////////////////////////////////////////
  // System side comes up in normal mode on bypass
  AST_CTL_RESET: assert property (@(posedge clk)
    rst |=> ctl.path == BST_PATH_BYP && !ctl.test_mode)
    else $error("control outputs not reset");

endmodule
`default_nettype wire

// ---- bench/bst_jtag_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  logic line;
  // Released pin is pulled up, so never trust a stale tdo
  assign line = tdo_oe_n ? 1'b1 : tdo;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  ////////////////////////////////////////
  // Clock only runs inside a step; it stands low between frames
  task automatic step(input logic m, input logic d, output logic q);
    #1;
    tms <= m;
    tdi <= d;
    #79;
    q = line;
    tck <= 1'b1;
    #80;
    tck <= 1'b0;
  endtask
  task automatic run_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // Idle to idle; pause after p bits when 0 < p < n
  task automatic scan(input logic ir, input int n, input int p, input logic [17:0] din,
                      output logic [17:0] dout, output logic [1:0] oe);
    logic q;
    dout = '0;
    oe = 2'b11;
    step(1'b1, 1'b1, q);
    if (ir) begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p - 1, din[i], dout[i]);
      if (i == 0) begin
        oe[1] = tdo_oe_n;
      end
      if (i == p - 1 && i != n - 1) begin
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        oe[0] = tdo_oe_n;
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
      end
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// ---- bench/bst_tap_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bst_tap_tb;
  import bst_pkg::*;
  logic clk;
  logic rst;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  bst_pin_type pins;
  bst_ctl_type ctl;
  logic [17:0] got;
  logic [1:0] oe;
  int n_mismatch;
  int checked;
  bst_tap u_dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .pins(pins), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .ctl(ctl));
  bst_jtag_model u_jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk_scan(input string what, input logic [17:0] exp, input logic [17:0] seen);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Control outputs cross domains, so allow a few clocks to land
  task automatic chk_ctl(input string what, input bst_ctl_type exp);
    repeat (8) @(posedge clk);
    checked++;
    if (ctl !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, ctl);
    end
  endtask
  task automatic ir(input logic [7:0] code, input int p);
    u_jtag.scan(1'b1, 8, p, {10'h0, code}, got, oe);
    chk_scan("ir capture", 18'h81, got & 18'hFF);
    chk_scan("ir release", 18'h1, {16'h0, oe});
  endtask
  task automatic close_out();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    pins = '0;
    n_mismatch = 0;
    checked = 0;
    fork
      begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
      end
      u_jtag.run_reset();
    join
    u_jtag.run_reset();
    chk_ctl("reset", '{1'b0, BST_PATH_BYP, 18'h0, 2'h2});
    @(posedge clk);
    pins <= '{2'b10, 8'hA5, 8'h3C};
    ir(8'h02, 3);
    chk_ctl("sample", '{1'b0, BST_PATH_BSR, 18'h0, 2'h2});
    u_jtag.scan(1'b0, 18, 7, 18'h2D13B, got, oe);
    chk_scan("chain capture", {2'b10, 8'hA5, 8'h3C}, got);
    chk_scan("chain release", 18'h1, {16'h0, oe});
    chk_ctl("chain update", '{1'b0, BST_PATH_BSR, 18'h2D13B, 2'h2});
    ir(8'h80, 0);
    chk_ctl("bit7 ignored", '{1'b1, BST_PATH_BSR, 18'h2D13B, 2'h2});
    ir(8'h05, 5);
    chk_ctl("unlisted", '{1'b0, BST_PATH_BYP, 18'h2D13B, 2'h2});
    u_jtag.scan(1'b0, 4, 0, 18'hB, got, oe);
    chk_scan("bypass", 18'h6, got);
    chk_ctl("bypass update", '{1'b0, BST_PATH_BYP, 18'h2D13B, 2'h2});
    ir(8'h0E, 0);
    u_jtag.scan(1'b0, 2, 0, 18'h1, got, oe);
    chk_scan("control capture", 18'h2, got);
    chk_ctl("control update", '{1'b0, BST_PATH_BCR, 18'h2D13B, 2'h1});
    u_jtag.run_reset();
    chk_ctl("tap reset", '{1'b0, BST_PATH_BYP, 18'h2D13B, 2'h2});
    close_out();
  end
endmodule
`default_nettype wire
